//--- rtl/mmx_memory_bus.sv
`timescale 1ns/100ps
// Summary of operation
// - with select high at power-on, fetch outside when past internal flash size
// - with select low at power-on, fetch the full 64k-byte space outside
// - external fetch drives ports 0 and 2 and pulses program store strobe
// - access select pin caught once after power-on; later changes ignored
// - code lock 0 blocks table reads of internal flash by external code
// - 8-bit internal address; above 7fh direct is sfr, indirect upper ram
// - only sfr addresses ending in 0h or 8h are bit-addressable
// - lowest 32 bytes are four register banks chosen by status word bits 3,4
// - bytes 20h..2fh reachable as bits 00h..7fh
// - stack pointer resets to 07h; push pre-increments, pop post-decrements
// - aux ram at 000h..3ffh while aux ram select set, else external
// - 16-bit data access: port 0 low address/data, port 2 high, read/write strobes
// - 8-bit data access drives only port 0 and strobes; port 2 left free
// - low address valid on port 0 at falling edge of latch strobe
// - write data on port 0 before write strobe and held after it ends
// - read data sampled from port 0 just before read strobe ends
// - every external access loads 0ffh into the port 0 latch
// - field update disabled while running externally
// - base register gives data flash start high byte, reloaded from config
// - base register writes only take effect under timed access
// - base config 00h makes all flash data flash; execution goes outside unless running from the loader
// - data flash exists only with allow bit 0; else code covers 64k
module mmx_memory_bus (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // straps and configuration
  input  wire logic        ext_access_select,
  input  wire logic [7:0]  config_byte_zero,
  input  wire logic [7:0]  config_byte_one,
  input  wire logic        running_from_loader,
  // core side request
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_kind,
  input  wire logic        req_wide,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  input  wire logic        table_read,
  // internal data space request
  input  wire logic [7:0]  int_addr,
  input  wire logic        int_indirect,
  input  wire logic        int_bit_op,
  input  wire logic [7:0]  program_status_word,
  input  wire logic [7:0]  chip_control_reg,
  // stack
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire logic        stack_load,
  input  wire logic [7:0]  stack_load_val,
  // data flash base register port
  input  wire logic        base_wr,
  input  wire logic [7:0]  base_wdata,
  input  wire logic        timed_access,
  // core side answers
  output logic             req_done,
  output logic [7:0]       req_rdata,
  output logic             fetch_external,
  output logic             aux_ram_hit,
  output logic             table_blocked,
  output logic             field_update_allow,
  output logic [7:0]       data_flash_base_high,
  output logic [15:0]      app_flash_top,
  output logic [7:0]       int_ram_addr,
  output logic             int_sfr_sel,
  output logic [7:0]       bit_byte_addr,
  output logic [2:0]       bit_index,
  output logic             bit_sfr_sel,
  output logic [7:0]       stack_pointer,
  output logic [7:0]       stack_ram_addr,
  output logic [7:0]       port0_latch,
  // external pins
  input  wire logic [7:0]  port0_in,
  output logic [7:0]       port0_out,
  output logic             port0_oe,
  output logic [7:0]       port2_out,
  output logic             port2_oe,
  output logic             addr_latch_strobe,
  output logic             program_store_strobe_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n
);

  // ----------------------------------------------------------------
  // power-on strap and flash boundary
  // ----------------------------------------------------------------
  logic strap_taken;
  logic ext_sel_high;

  // strap is caught on the first clock after release, then frozen
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_taken  <= 1'b0;
      ext_sel_high <= 1'b1;
    end else if (!strap_taken) begin
      strap_taken  <= 1'b1;
      ext_sel_high <= ext_access_select;
    end
  end

  // base register reloads from config on every reset, then timed writes only
  logic base_loaded;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      base_loaded          <= 1'b0;
      data_flash_base_high <= 8'h00;
    end else if (!base_loaded) begin
      base_loaded          <= 1'b1;
      data_flash_base_high <= config_byte_one;
    end else if (base_wr && timed_access) begin
      data_flash_base_high <= base_wdata;
    end
  end

  // flash split: the base byte marks where data flash starts and code ends
  wire flash_split  = !config_byte_zero[mmx_pkg::FLASH_ALLOW_POS];
  wire no_app_flash = flash_split && (data_flash_base_high == 8'h00);
  wire [15:0] next_app_top = flash_split
         ? ({data_flash_base_high, mmx_pkg::FLASH_LOW_BYTE} - 16'd1)
         : 16'hFFFF;
  wire [15:0] region_top = running_from_loader ? mmx_pkg::LOADER_TOP : app_flash_top;
  // fetch outside: strap low, no application region, or pc past the region
  wire next_fetch_ext = !ext_sel_high
         || (!running_from_loader && no_app_flash)
         || (req_addr > region_top);
  wire next_table_blk = table_read && fetch_external
         && !config_byte_zero[mmx_pkg::CODE_LOCK_POS];

  // ----------------------------------------------------------------
  // internal data space decode
  // ----------------------------------------------------------------
  // register banks: two status word bits pick one group of eight
  wire [1:0] bank = {program_status_word[mmx_pkg::BANK_HIGH_POS],
                     program_status_word[mmx_pkg::BANK_LOW_POS]};
  wire       is_reg = (int_addr[7:3] == 5'd0) && int_bit_op == 1'b0 && int_indirect == 1'b0;
  wire [7:0] next_ram_addr = is_reg ? {3'b000, bank, int_addr[2:0]} : int_addr;
  wire       next_sfr_sel = (int_addr > mmx_pkg::LOW_RAM_TOP) && !int_indirect;
  // bit addresses up to 7fh land in ram bytes 20h..2fh, the rest in sfrs
  wire       bit_in_ram = int_addr <= mmx_pkg::BIT_ADDR_TOP;
  wire [7:0] next_bit_byte = bit_in_ram
         ? (mmx_pkg::BIT_RAM_BASE + {4'h0, int_addr[6:3]})
         : {int_addr[7:3], 3'b000};

  // only data requests can land in aux ram; code fetches never do
  wire aux_hit_now = chip_control_reg[mmx_pkg::AUX_RAM_SEL_POS]
         && (req_addr <= mmx_pkg::AUX_RAM_TOP) && req_kind != 2'(mmx_pkg::MMX_CODE);

  // registered decode outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_ram_addr       <= 8'h00;
      int_sfr_sel        <= 1'b0;
      bit_byte_addr      <= 8'h00;
      bit_index          <= 3'd0;
      bit_sfr_sel        <= 1'b0;
      fetch_external     <= 1'b0;
      table_blocked      <= 1'b0;
      aux_ram_hit        <= 1'b0;
      field_update_allow <= 1'b0;
      app_flash_top      <= 16'hFFFF;
    end else begin
      int_ram_addr       <= next_ram_addr;
      int_sfr_sel        <= next_sfr_sel;
      bit_byte_addr      <= next_bit_byte;
      bit_index          <= int_addr[2:0];
      bit_sfr_sel        <= !bit_in_ram;
      fetch_external     <= next_fetch_ext;
      table_blocked      <= next_table_blk;
      aux_ram_hit        <= req_valid && aux_hit_now;
      field_update_allow <= !fetch_external;
      app_flash_top      <= next_app_top;
    end
  end

  // ----------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------
  // pushes write at the incremented pointer, pops read at the current one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stack_pointer  <= mmx_pkg::SP_RESET;
      stack_ram_addr <= mmx_pkg::SP_RESET;
    end else if (stack_load) begin
      stack_pointer  <= stack_load_val;
      stack_ram_addr <= stack_load_val;
    end else if (stack_push) begin
      stack_pointer  <= stack_pointer + 8'd1;
      stack_ram_addr <= stack_pointer + 8'd1;
    end else if (stack_pop) begin
      stack_ram_addr <= stack_pointer;
      stack_pointer  <= stack_pointer - 8'd1;
    end
  end

  // ----------------------------------------------------------------
  // external bus sequencer
  // ----------------------------------------------------------------
  // one shared timer paces all four phases of a bus cycle
  mmx_phase_if ph ();
  mmx_phase_timer u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .ph       (ph)
  );

  // captured request, held for the whole bus cycle
  mmx_pkg::mmx_state_t state;
  mmx_pkg::mmx_kind_t  kind;
  logic                wide;
  logic [15:0]         addr;
  logic [7:0]          wdata;

  // code fetches go outside only when fetching externally; aux ram stays inside
  wire is_code   = req_kind == 2'(mmx_pkg::MMX_CODE);
  // a request still raised while done is shown is the one just finished,
  // so it must not start a second bus cycle
  wire ext_start = req_valid && !req_done && state == mmx_pkg::MMX_IDLE
                   && (is_code ? next_fetch_ext : !aux_hit_now);
  wire phase_end = ph.done;
  assign ph.start = ext_start || (phase_end && state != mmx_pkg::MMX_IDLE
                                  && state != mmx_pkg::MMX_HOLD);

  // four phases of two clocks each; the timer's done ends every phase,
  // and the end of hold returns to idle with done shown for one clock
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= mmx_pkg::MMX_IDLE;
      kind  <= mmx_pkg::MMX_CODE;
      wide  <= 1'b0;
      addr  <= 16'h0000;
      wdata <= 8'h00;
    end else begin
      case (state)
        mmx_pkg::MMX_IDLE: begin
          if (ext_start) begin
            state <= mmx_pkg::MMX_ADDR;
            kind  <= mmx_pkg::mmx_kind_t'(req_kind);
            wide  <= req_wide || is_code;
            addr  <= req_addr;
            wdata <= req_wdata;
          end
        end
        mmx_pkg::MMX_ADDR:   if (phase_end) state <= mmx_pkg::MMX_LATCH;
        mmx_pkg::MMX_LATCH:  if (phase_end) state <= mmx_pkg::MMX_STROBE;
        mmx_pkg::MMX_STROBE: if (phase_end) state <= mmx_pkg::MMX_HOLD;
        default:             if (phase_end) state <= mmx_pkg::MMX_IDLE;
      endcase
    end
  end

  wire in_addr   = state == mmx_pkg::MMX_ADDR;
  wire in_latch  = state == mmx_pkg::MMX_LATCH;
  wire in_strobe = state == mmx_pkg::MMX_STROBE;
  wire in_hold   = state == mmx_pkg::MMX_HOLD;
  wire busy      = state != mmx_pkg::MMX_IDLE;
  wire is_write  = kind == mmx_pkg::MMX_DATA_WRITE;
  // the address stays driven through the edge at which the latch strobe
  // falls, so the external latch never sees data while it closes
  wire hold_addr = in_addr || (in_latch && !phase_end);
  // write data comes one clock before the write strobe falls
  wire [7:0] next_p0 = hold_addr ? addr[7:0] : (is_write ? wdata : port0_out);
  wire next_p0_oe = hold_addr || (is_write && busy);
  // read data is taken on the last clock the strobe is low, which gives
  // slow memories the whole strobe width
  wire sample_rd  = in_hold && !phase_end && !is_write;

  // ----------------------------------------------------------------
  // pin and answer registers
  // ----------------------------------------------------------------
  // every pin comes from a flop, so decode glitches never reach the bus
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port0_out              <= 8'h00;
      port0_oe               <= 1'b0;
      port2_out              <= 8'h00;
      port2_oe               <= 1'b0;
      addr_latch_strobe      <= 1'b0;
      program_store_strobe_n <= 1'b1;
      read_strobe_n          <= 1'b1;
      write_strobe_n         <= 1'b1;
      req_done               <= 1'b0;
      req_rdata              <= 8'h00;
      port0_latch            <= mmx_pkg::PORT0_IDLE;
    end else begin
      port0_out <= next_p0;
      port0_oe  <= next_p0_oe;
      port2_out <= addr[15:8];
      port2_oe  <= busy && wide;
      addr_latch_strobe      <= in_addr;
      program_store_strobe_n <= !(in_strobe && kind == mmx_pkg::MMX_CODE);
      read_strobe_n          <= !(in_strobe && kind == mmx_pkg::MMX_DATA_READ);
      write_strobe_n         <= !(in_strobe && is_write);
      req_done               <= state == mmx_pkg::MMX_HOLD && phase_end;
      if (sample_rd) begin
        req_rdata <= port0_in;
      end
      if (ext_start) begin
        port0_latch <= mmx_pkg::PORT0_IDLE;
      end
    end
  end

endmodule // mmx_memory_bus

//--- rtl/mmx_phase_if.sv
`timescale 1ns/100ps
// phase counter link between the sequencer and its timer
interface mmx_phase_if;
  logic start;
  logic done;
  modport seq (output start, input done);
  modport tmr (input start, output done);
endinterface

//--- rtl/mmx_phase_timer.sv
`timescale 1ns/100ps
// counts core clocks for one bus phase; restarts on every start pulse
module mmx_phase_timer (
  input  wire logic   core_clk,
  input  wire logic   rst,
  mmx_phase_if.tmr    ph
);
  logic [1:0] count;

  // done rises after PHASE_CYCLES clocks
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= 2'd0;
    end else if (ph.start) begin
      count <= mmx_pkg::PHASE_CYCLES - 2'd1;
    end else if (count != 2'd0) begin
      count <= count - 2'd1;
    end
  end

  // done must not look at start: start is built from done, and the pair would loop
  assign ph.done = (count == 2'd0);
endmodule // mmx_phase_timer

//--- rtl/mmx_pkg.sv
package mmx_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [7:0]  LOW_RAM_TOP    = 8'h7F;    // above: sfr (direct) or upper ram
  localparam logic [7:0]  BIT_RAM_BASE   = 8'h20;    // bit-addressable ram bytes 20h..2fh
  localparam logic [7:0]  BIT_ADDR_TOP   = 8'h7F;    // bit addresses 00h..7fh live in ram
  localparam logic [15:0] AUX_RAM_TOP    = 16'h03FF; // 1024 bytes of on-chip aux ram
  localparam logic [7:0]  FLASH_LOW_BYTE = 8'h00;    // data flash start low byte
  localparam logic [7:0]  PORT0_IDLE     = 8'hFF;    // port 0 latch value after a bus cycle
  localparam logic [7:0]  SP_RESET       = 8'h07;    // stack pointer after reset
  localparam logic [15:0] LOADER_TOP     = 16'h09FF; // last loader flash address, arbitrary default

  // ----------------------------------------------------------------
  // bit positions
  // ----------------------------------------------------------------
  localparam int BANK_LOW_POS     = 3;  // bank_select_low in program_status_word
  localparam int BANK_HIGH_POS    = 4;  // bank_select_high
  localparam int AUX_RAM_SEL_POS  = 4;  // aux_ram_select in chip_control_reg
  localparam int CODE_LOCK_POS    = 2;  // code_read_lock in config_byte_zero
  localparam int FLASH_ALLOW_POS  = 0;  // data_flash_allow in config_byte_zero

  // ----------------------------------------------------------------
  // bus cycle sequencing, in core clocks per phase
  // ----------------------------------------------------------------
  localparam logic [1:0] PHASE_CYCLES = 2'd2;

  typedef enum logic [2:0] {
    MMX_IDLE,
    MMX_ADDR,
    MMX_LATCH,
    MMX_STROBE,
    MMX_HOLD
  } mmx_state_t;

  typedef enum logic [1:0] {
    MMX_CODE,
    MMX_DATA_READ,
    MMX_DATA_WRITE
  } mmx_kind_t;

endpackage

//--- tb/mmx_ext_mem.sv
`timescale 1ns/100ps
// ----
// external program and data memory behind the latch
// ----
module mmx_ext_mem (
  input  wire logic       addr_latch_strobe,
  input  wire logic       program_store_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic       slow,
  input  wire logic [7:0] port0_out,
  input  wire logic [7:0] port2_line,
  output logic      [7:0] bus_drive
);
  logic [7:0] lo_addr;
  logic [7:0] q;
  logic       ready;
  logic [7:0] mem [logic [15:0]];
  // latch takes the low byte on the falling edge
  always @(negedge addr_latch_strobe) lo_addr = port0_out;
  // byte taken as the strobe ends; page comes from port 2 pins
  always @(posedge write_strobe_n) begin
    if (!$isunknown({port2_line, lo_addr})) mem[{port2_line, lo_addr}] = port0_out;
  end
  // data is valid only after the access time; slow answers late
  always @(negedge read_strobe_n or negedge program_store_strobe_n) begin
    ready = 1'b0;
    q = mem.exists({port2_line, lo_addr}) ? mem[{port2_line, lo_addr}] :
        lo_addr ^ port2_line ^ 8'h5a;
    #(slow ? 30 : 3);
    ready = !(read_strobe_n && program_store_strobe_n);
  end
  always @(posedge read_strobe_n or posedge program_store_strobe_n) ready = 1'b0;
  // released bus shows the inverse so stale data cannot match
  assign bus_drive = ready ? q : ~lo_addr;
endmodule // mmx_ext_mem

//--- tb/mmx_memory_bus_properties.sv
`timescale 1ns/100ps
// ----
// bus timing and decode checks
// ----
module mmx_bus_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        req_wide,
  input wire logic [15:0] req_addr,
  input wire logic [7:0]  int_addr,
  input wire logic        int_indirect,
  input wire logic        int_bit_op,
  input wire logic        stack_push,
  input wire logic        stack_pop,
  input wire logic        stack_load,
  input wire logic        base_wr,
  input wire logic        timed_access,
  input wire logic        req_done,
  input wire logic        int_sfr_sel,
  input wire logic [7:0]  stack_pointer,
  input wire logic [7:0]  data_flash_base_high,
  input wire logic [7:0]  port0_latch,
  input wire logic [7:0]  port0_out,
  input wire logic        port0_oe,
  input wire logic [7:0]  port2_out,
  input wire logic        port2_oe,
  input wire logic        addr_latch_strobe,
  input wire logic        program_store_strobe_n,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // strobe shapes and port drive
  AST_ALE_WIDTH: assert property (
    $rose(addr_latch_strobe) |=> addr_latch_strobe ##1 !addr_latch_strobe)
    else $error("latch strobe width wrong");
  AST_ALE_ADDR: assert property (
    $fell(addr_latch_strobe) |-> port0_oe && port0_out == $past(port0_out))
    else $error("low address not steady at latch edge");
  AST_WR_HOLD: assert property (
    $fell(write_strobe_n) |-> (port0_oe && $stable(port0_out)) [*3] ##0 write_strobe_n)
    else $error("write data not held around strobe");
  AST_RD_RELEASE: assert property (
    !read_strobe_n |-> !port0_oe)
    else $error("port 0 driven during read");
  AST_P2_WIDTH: assert property (
    !read_strobe_n || !write_strobe_n |-> port2_oe == req_wide)
    else $error("port 2 drive does not follow address width");
  AST_P2_HIGH: assert property (
    (!read_strobe_n && req_wide) || !program_store_strobe_n |->
      port2_oe && port2_out == req_addr[15:8])
    else $error("port 2 high address wrong");
  AST_DONE_LATCH: assert property (
    req_done |-> port0_latch == mmx_pkg::PORT0_IDLE)
    else $error("port 0 latch not reloaded");
  // stack, base register and internal decode
  AST_SP_PUSH: assert property (
    stack_push && !stack_pop && !stack_load |=> stack_pointer == $past(stack_pointer) + 8'h01)
    else $error("push did not pre-increment");
  AST_BASE_LOCK: assert property (
    base_wr && !timed_access |=> $stable(data_flash_base_high))
    else $error("unprotected base write took effect");
  AST_SFR_DIRECT: assert property (
    !int_indirect && !int_bit_op |=> int_sfr_sel == ($past(int_addr) > mmx_pkg::LOW_RAM_TOP))
    else $error("direct decode wrong");
endmodule // mmx_bus_chk
bind mmx_memory_bus mmx_bus_chk i_mmx_bus_chk (.*);

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic        core_clk, rst, ext_access_select, running_from_loader, table_read;
  logic        req_valid, req_wide, int_indirect, int_bit_op, stack_push, stack_pop;
  logic        stack_load, base_wr, timed_access, req_done, fetch_external, aux_ram_hit;
  logic        table_blocked, field_update_allow, int_sfr_sel, bit_sfr_sel, port0_oe;
  logic        port2_oe, addr_latch_strobe, program_store_strobe_n, read_strobe_n;
  logic        write_strobe_n, slow;
  logic [1:0]  req_kind;
  logic [2:0]  bit_index;
  logic [15:0] req_addr, app_flash_top, a, key;
  logic [7:0]  config_byte_zero, config_byte_one, req_wdata, int_addr, program_status_word;
  logic [7:0]  chip_control_reg, stack_load_val, base_wdata, req_rdata, data_flash_base_high;
  logic [7:0]  int_ram_addr, bit_byte_addr, stack_pointer, stack_ram_addr, port0_latch;
  logic [7:0]  port0_in, port0_out, port2_out, page, rq, sp, bus_drive, ia;
  logic [31:0] r;
  int          err_count, n_checks;
  logic [7:0]  exp_mem [logic [15:0]];
  wire  [7:0]  port2_line = port2_oe ? port2_out : page;
  assign port0_in = port0_oe ? port0_out : bus_drive;

  mmx_memory_bus i_mmx_memory_bus (.*);
  mmx_ext_mem i_mmx_ext_mem (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_rd(logic [15:0] k);
    return exp_mem.exists(k) ? exp_mem[k] : k[7:0] ^ k[15:8] ^ 8'h5a;
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset(logic s, logic [7:0] c0, logic [7:0] c1);
    rst <= 1'b1;
    ext_access_select <= s;
    config_byte_zero <= c0;
    config_byte_one <= c1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic fetch_chk(logic [15:0] fa, logic e);
    req_kind <= 2'd0;
    req_addr <= fa;
    repeat (3) @(posedge core_clk);
    chk(fetch_external, e);
  endtask
  // request held until the one-cycle done pulse, dropped at the next edge
  task automatic bus(logic [1:0] k, logic w, logic [15:0] ba, logic [7:0] d);
    int i;
    @(posedge core_clk);
    req_kind <= k;
    req_wide <= w;
    req_addr <= ba;
    req_wdata <= d;
    req_valid <= 1'b1;
    for (i = 0; i < 40 && req_done !== 1'b1; i++) @(negedge core_clk);
    chk(req_done, 1'b1);
    rq = req_rdata;
    @(posedge core_clk);
    req_valid <= 1'b0;
  endtask
  task automatic base_write(logic [7:0] v, logic t);
    @(posedge core_clk);
    base_wdata <= v;
    base_wr <= 1'b1;
    timed_access <= t;
    @(posedge core_clk);
    base_wr <= 1'b0;
    timed_access <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    {rst, r} = {1'b1, 32'h0f1b_1be3};
    {ext_access_select, running_from_loader, table_read, req_valid, req_wide} = '0;
    {int_indirect, int_bit_op, stack_push, stack_pop, stack_load, base_wr} = '0;
    {timed_access, slow, req_kind, req_addr, req_wdata, int_addr, page} = '0;
    {config_byte_zero, config_byte_one, program_status_word, chip_control_reg} = '0;
    {stack_load_val, base_wdata} = '0;
    do_reset(1'b1, 8'h00, 8'h80);
    chk(stack_pointer, 8'h07);
    chk(data_flash_base_high, 8'h80);
    chk(app_flash_top, 16'h7fff);
    fetch_chk(16'h1000, 1'b0);
    fetch_chk(16'h9000, 1'b1);
    chk(field_update_allow, 1'b0);
    table_read <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(table_blocked, 1'b1);
    table_read <= 1'b0;
    bus(2'd0, 1'b1, 16'h9000, 8'h00);
    chk(rq, exp_rd(16'h9000));
    ext_access_select <= 1'b0;
    fetch_chk(16'h1000, 1'b0);
    // aux range with select cleared goes out, then random traffic
    for (int n = 0; n < 17; n++) begin
      r = lfsr(r);
      page <= r[31:24];
      slow <= r[4];
      chip_control_reg <= {3'b000, r[5] && n > 0, 4'h0};
      a = (n == 0) ? 16'h0123 : r[5] ? {6'h00, r[25:16]} : {r[15:8] | 8'h04, r[23:16]};
      if (r[5] && n > 0) begin
        @(posedge core_clk);
        req_kind <= 2'd2;
        req_addr <= a;
        req_valid <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(aux_ram_hit, 1'b1);
        req_valid <= 1'b0;
        @(posedge core_clk);
      end else begin
        key = (r[6] || n == 0) ? a : {r[31:24], a[7:0]};
        bus(2'd2, r[6] || n == 0, a, r[7:0]);
        exp_mem[key] = r[7:0];
        bus(2'd1, r[6] || n == 0, a, 8'h00);
        chk(rq, exp_rd(key));
      end
    end
    // internal data space decode
    repeat (16) begin
      r = lfsr(r);
      ia = r[19] ? {5'h00, r[2:0]} : r[7:0];
      int_addr <= ia;
      int_indirect <= r[8];
      int_bit_op <= r[9];
      program_status_word <= r[17:10];
      repeat (3) @(posedge core_clk);
      if (r[9]) begin
        chk(bit_byte_addr, ia[7] ? {ia[7:3], 3'b000} : 8'h20 + ia[7:3]);
        chk({bit_sfr_sel, bit_index}, {ia[7], ia[2:0]});
      end else begin
        chk(int_sfr_sel, ia[7] && !r[8]);
        chk(int_ram_addr, (~|ia[7:3] && !r[8]) ? {3'b000, r[14:13], ia[2:0]} : ia);
      end
    end
    // stack moves from a loaded start
    sp = r[15:8];
    stack_load_val <= sp;
    stack_load <= 1'b1;
    @(posedge core_clk);
    stack_load <= 1'b0;
    repeat (12) begin
      r = lfsr(r);
      stack_push <= r[0];
      stack_pop <= !r[0];
      @(posedge core_clk);
      {stack_push, stack_pop} <= 2'b00;
      sp = r[0] ? sp + 8'h01 : sp - 8'h01;
      @(posedge core_clk);
      @(posedge core_clk);
      chk(stack_pointer, sp);
      chk(stack_ram_addr, r[0] ? sp : sp + 8'h01);
    end
    base_write(8'h40, 1'b0);
    chk(data_flash_base_high, 8'h80);
    base_write(8'h40, 1'b1);
    chk(app_flash_top, 16'h3fff);
    do_reset(1'b0, 8'h00, 8'h80);
    fetch_chk(16'h0100, 1'b1);
    do_reset(1'b1, 8'h00, 8'h00);
    fetch_chk(16'h0000, 1'b1);
    do_reset(1'b1, 8'h01, 8'h80);
    chk(app_flash_top, 16'hffff);
    fetch_chk(16'h9000, 1'b0);
    test_done;
  end

  // watchdog well past the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    test_done;
  end
endmodule // tb
